//--- verilog/lvcd_pkg.sv
// constants for the lvpecl channel divider block
package lvcd_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_CH1_CYCLE_COUNTS   = 10'h193;
    localparam logic [9:0] IDX_CH1_START_PHASE    = 10'h194;
    localparam logic [9:0] IDX_CH1_OUTPUT_ROUTING = 10'h195;
    localparam logic [9:0] IDX_CH2_CYCLE_COUNTS   = 10'h196;
    localparam logic [9:0] IDX_CH2_CONTROL        = 10'h197;
    localparam logic [9:0] IDX_CH2_OUTPUT_ROUTING = 10'h198;
    localparam logic [9:0] IDX_DIST_SOURCE        = 10'h1e1;
    localparam logic [9:0] IDX_STATUS             = 10'h1f0;

    // control register fields
    localparam int BIT_BYPASS      = 7;
    localparam int BIT_IGNORE_SYNC = 6;
    localparam int BIT_FORCE_LEVEL = 5;
    localparam int BIT_START_HIGH  = 4;
    localparam int PHASE_MSB       = 3;
    localparam int PHASE_LSB       = 0;
    // cycle count fields
    localparam int LOW_MSB         = 7;
    localparam int LOW_LSB         = 4;
    localparam int HIGH_MSB        = 3;
    localparam int HIGH_LSB        = 0;
    // routing fields
    localparam int BIT_DIRECT_OUT  = 1;
    localparam int BIT_DUTY_CORRECTION_DISABLE = 0;

    // distribution source select codes
    localparam logic [1:0] SRC_EXT_CLOCK = 2'h0;
    localparam logic [1:0] SRC_NO_EFFECT = 2'h1;
    localparam logic [1:0] SRC_OSC       = 2'h2;

    // reset values
    localparam logic [7:0] RST_CH1_CYCLE_COUNTS   = 8'h00;
    localparam logic [7:0] RST_CH1_START_PHASE    = 8'h00;
    localparam logic [7:0] RST_CH1_OUTPUT_ROUTING = 8'h00;
    localparam logic [7:0] RST_CH2_CYCLE_COUNTS   = 8'h00;
    localparam logic [7:0] RST_CH2_CONTROL        = 8'h80;
    localparam logic [7:0] RST_CH2_OUTPUT_ROUTING = 8'h00;
    localparam logic [1:0] RST_DIST_SOURCE        = 2'h1;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- verilog/lvcd_top.sv
// lvpecl channel divider pair with axi4-lite register slave
// Function
// [RL1] low phase lasts low-count field plus one input clock cycles
// [RL2] high phase lasts high-count field plus one input clock cycles
// [RL3] count zero gives one cycle per phase; both count fields reset to zero
// [RL4] bypass powers down divider and passes input clock to output
// [RL5] second divider comes up bypassed after reset
// [RL6] ignore-sync clear obeys chip sync; set ignores it; resets clear
// [RL7] software sets ignore-sync whenever it uses force level
// [RL8] force-level bit selects static output level; resets to low (code forces high only; clear leaves divider running)
// [RL9] start-level bit picks starting phase high or low; resets low
// [RL10] four-bit phase offset delays the divider output; resets zero
// [RL11] direct-to-output clear drives third pair from second divider
// [RL12] direct-to-output with source 10b routes oscillator straight to pair
// [RL13] direct-to-output with source 00b routes external clock to pair
// [RL14] source 01b makes direct-to-output ineffective; divider keeps driving
// [RL15] routing bit 0 set disables duty correction; clear applies it
// [RL16] first divider offers same direct routing for second pair
// [RL17] first divider start level bit 4, phase offset low nibble, reset zero
// [RL18] first divider comes up active, not bypassed
// [RL19] total ratio is low plus one plus high plus one, 2 to 32
// [RL20] accepted sync restarts count from start level after phase offset
`timescale 1ns/1ps
module lvcd_top #(
    parameter int ADDR_W = 12
) (
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              dist_clk,
    input  wire logic              internal_oscillator,
    input  wire logic              ext_clk,
    input  wire logic              chip_sync,
    output logic                   pair_b_out_p,
    output logic                   pair_b_out_n,
    output logic                   pair_c_out_p,
    output logic                   pair_c_out_n,
    output logic [1:0]             duty_correct_on
);

    typedef struct packed {
        logic [7:0]        ch1_cnt;
        logic [7:0]        ch1_ctl;
        logic [7:0]        ch1_rt;
        logic [7:0]        ch2_cnt;
        logic [7:0]        ch2_ctl;
        logic [7:0]        ch2_rt;
        logic [1:0]        src;
        logic [2:0]        din_s;
        logic [2:0]        osc_s;
        logic [2:0]        ext_s;
        logic [2:0]        sync_s;
        logic [1:0]        lvl;
        logic [1:0][3:0]   cnt;
        logic [1:0][3:0]   wait_cnt;
        logic [1:0]        out;
        logic              aw_ok;
        logic [ADDR_W-1:0] awaddr;
        logic              w_ok;
        logic [7:0]        wdata;
        logic              wlane;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [7:0]        rdata;
    } lvcd_state_type;

    lvcd_state_type st_q;
    lvcd_state_type st_d;

    logic [1:0][7:0] cnt_reg;
    logic [1:0][7:0] ctl_reg;
    logic [1:0][7:0] rt_reg;
    logic [1:0]      div_lvl;
    logic            din_rise;
    logic            sync_on;
    logic            sync_rise;
    logic [9:0]      w_idx;
    logic [9:0]      r_idx;
    logic [3:0]      limit;
    logic            w_fire;
    logic            r_fire;

    assign cnt_reg = {st_q.ch2_cnt, st_q.ch1_cnt};
    assign ctl_reg = {st_q.ch2_ctl, st_q.ch1_ctl};
    assign rt_reg  = {st_q.ch2_rt, st_q.ch1_rt};

    // edge detects read only the second stage and its follower
    assign din_rise  = st_q.din_s[1] & ~st_q.din_s[2];
    assign sync_on   = st_q.sync_s[1];
    assign sync_rise = st_q.sync_s[1] & ~st_q.sync_s[2];

    assign w_idx  = st_q.awaddr[11:2];
    assign r_idx  = s_axi_araddr[11:2];
    assign w_fire = st_q.aw_ok & st_q.w_ok & ~st_q.bvalid;
    assign r_fire = s_axi_arvalid & ~st_q.rvalid;

    assign s_axi_awready = ~st_q.aw_ok & ~st_q.bvalid;
    assign s_axi_wready  = ~st_q.w_ok & ~st_q.bvalid;
    assign s_axi_arready = ~st_q.rvalid;
    assign s_axi_bvalid  = st_q.bvalid;
    assign s_axi_bresp   = st_q.bresp;
    assign s_axi_rvalid  = st_q.rvalid;
    assign s_axi_rresp   = st_q.rresp;
    assign s_axi_rdata   = {24'h000000, st_q.rdata};

    assign pair_b_out_p = st_q.out[0];
    assign pair_b_out_n = ~st_q.out[0];
    assign pair_c_out_p = st_q.out[1];
    assign pair_c_out_n = ~st_q.out[1];

    // [RL15] duty correction flags
    assign duty_correct_on[0] = ~st_q.ch1_rt[lvcd_pkg::BIT_DUTY_CORRECTION_DISABLE];
    assign duty_correct_on[1] = ~st_q.ch2_rt[lvcd_pkg::BIT_DUTY_CORRECTION_DISABLE];

    always_comb
    begin
        st_d     = st_q;
        div_lvl  = 2'h0;
        limit    = 4'h0;

        // pins are outside the clock domain
        st_d.din_s  = {st_q.din_s[1:0], dist_clk};
        st_d.osc_s  = {st_q.osc_s[1:0], internal_oscillator};
        st_d.ext_s  = {st_q.ext_s[1:0], ext_clk};
        st_d.sync_s = {st_q.sync_s[1:0], chip_sync};

        for (int i = 0; i < 2; i++)
        begin
            if (ctl_reg[i][lvcd_pkg::BIT_BYPASS])
            begin
                // [RL4] counters held idle while bypassed
                st_d.lvl[i]      = 1'b0;
                st_d.cnt[i]      = 4'h0;
                st_d.wait_cnt[i] = 4'h0;
                div_lvl[i]       = st_q.din_s[1];
            end
            else
            begin
                // [RL6] sync honoured only with ignore-sync clear
                if (~ctl_reg[i][lvcd_pkg::BIT_IGNORE_SYNC] && (sync_on || sync_rise))
                begin
                    // [RL9] [RL20] restart at start level, offset armed
                    st_d.lvl[i]      = ctl_reg[i][lvcd_pkg::BIT_START_HIGH];
                    st_d.cnt[i]      = 4'h0;
                    st_d.wait_cnt[i] = ctl_reg[i][lvcd_pkg::PHASE_MSB:lvcd_pkg::PHASE_LSB];
                end
                else if (din_rise)
                begin
                    // [RL1] [RL2] phase length from count fields
                    limit = st_q.lvl[i] ? cnt_reg[i][lvcd_pkg::HIGH_MSB:lvcd_pkg::HIGH_LSB]
                                        : cnt_reg[i][lvcd_pkg::LOW_MSB:lvcd_pkg::LOW_LSB];
                    if (st_q.wait_cnt[i] != 4'h0)
                    begin
                        // [RL10] phase offset delay
                        st_d.wait_cnt[i] = st_q.wait_cnt[i] - 4'h1;
                    end
                    else if (st_q.cnt[i] >= limit)
                    begin
                        // [RL3] [RL19] zero count toggles every edge
                        // >= so a count lowered mid-phase cannot run on to wrap
                        st_d.lvl[i] = ~st_q.lvl[i];
                        st_d.cnt[i] = 4'h0;
                    end
                    else
                    begin
                        st_d.cnt[i] = st_q.cnt[i] + 4'h1;
                    end
                end
                // [RL8] static force high needs ignore-sync
                if (ctl_reg[i][lvcd_pkg::BIT_IGNORE_SYNC] && ctl_reg[i][lvcd_pkg::BIT_FORCE_LEVEL])
                begin
                    div_lvl[i] = 1'b1;
                end
                else
                begin
                    div_lvl[i] = st_q.lvl[i];
                end
            end

            // [RL11] [RL14] [RL16] direct routing select
            if (rt_reg[i][lvcd_pkg::BIT_DIRECT_OUT] && st_q.src == lvcd_pkg::SRC_OSC)
            begin
                // [RL12] oscillator straight out
                st_d.out[i] = st_q.osc_s[1];
            end
            else if (rt_reg[i][lvcd_pkg::BIT_DIRECT_OUT] && st_q.src == lvcd_pkg::SRC_EXT_CLOCK)
            begin
                // [RL13] external clock straight out
                st_d.out[i] = st_q.ext_s[1];
            end
            else
            begin
                st_d.out[i] = div_lvl[i];
            end
        end

        // write address and data taken in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            st_d.aw_ok  = 1'b1;
            st_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            st_d.w_ok  = 1'b1;
            st_d.wdata = s_axi_wdata[7:0];
            st_d.wlane = s_axi_wstrb[0];
        end
        if (w_fire)
        begin
            st_d.aw_ok  = 1'b0;
            st_d.w_ok   = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp  = lvcd_pkg::RESP_OKAY;
            // upper address bits outside the map decode as unmapped
            if (st_q.awaddr[ADDR_W-1:2] != {{(ADDR_W-12){1'b0}}, w_idx})
            begin
                st_d.bresp = lvcd_pkg::RESP_SLVERR;
            end
            else
            begin
                case (w_idx)
                    lvcd_pkg::IDX_CH1_CYCLE_COUNTS:
                        if (st_q.wlane) st_d.ch1_cnt = st_q.wdata;
                    lvcd_pkg::IDX_CH1_START_PHASE:
                        // [RL17] start level and offset of first divider
                        if (st_q.wlane) st_d.ch1_ctl = st_q.wdata;
                    lvcd_pkg::IDX_CH1_OUTPUT_ROUTING:
                        if (st_q.wlane) st_d.ch1_rt = {6'h00, st_q.wdata[1:0]};
                    lvcd_pkg::IDX_CH2_CYCLE_COUNTS:
                        if (st_q.wlane) st_d.ch2_cnt = st_q.wdata;
                    lvcd_pkg::IDX_CH2_CONTROL:
                        if (st_q.wlane) st_d.ch2_ctl = st_q.wdata;
                    lvcd_pkg::IDX_CH2_OUTPUT_ROUTING:
                        if (st_q.wlane) st_d.ch2_rt = {6'h00, st_q.wdata[1:0]};
                    lvcd_pkg::IDX_DIST_SOURCE:
                        if (st_q.wlane) st_d.src = st_q.wdata[1:0];
                    lvcd_pkg::IDX_STATUS:
                        st_d.bresp = lvcd_pkg::RESP_OKAY;
                    default:
                        st_d.bresp = lvcd_pkg::RESP_SLVERR;
                endcase
            end
        end
        if (st_q.bvalid && s_axi_bready)
        begin
            st_d.bvalid = 1'b0;
        end

        if (r_fire)
        begin
            st_d.rvalid = 1'b1;
            st_d.rresp  = lvcd_pkg::RESP_OKAY;
            st_d.rdata  = 8'h00;
            if (s_axi_araddr[ADDR_W-1:2] != {{(ADDR_W-12){1'b0}}, r_idx})
            begin
                st_d.rresp = lvcd_pkg::RESP_SLVERR;
            end
            else
            begin
                case (r_idx)
                    lvcd_pkg::IDX_CH1_CYCLE_COUNTS:   st_d.rdata = st_q.ch1_cnt;
                    lvcd_pkg::IDX_CH1_START_PHASE:    st_d.rdata = st_q.ch1_ctl;
                    lvcd_pkg::IDX_CH1_OUTPUT_ROUTING: st_d.rdata = st_q.ch1_rt;
                    lvcd_pkg::IDX_CH2_CYCLE_COUNTS:   st_d.rdata = st_q.ch2_cnt;
                    lvcd_pkg::IDX_CH2_CONTROL:        st_d.rdata = st_q.ch2_ctl;
                    lvcd_pkg::IDX_CH2_OUTPUT_ROUTING: st_d.rdata = st_q.ch2_rt;
                    lvcd_pkg::IDX_DIST_SOURCE:        st_d.rdata = {6'h00, st_q.src};
                    lvcd_pkg::IDX_STATUS:
                        st_d.rdata = {5'h00, sync_on, st_q.out};
                    default:
                        st_d.rresp = lvcd_pkg::RESP_SLVERR;
                endcase
            end
        end
        else if (st_q.rvalid && s_axi_rready)
        begin
            st_d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q          <= '0;
            // [RL3] count fields reset to zero
            st_q.ch1_cnt  <= lvcd_pkg::RST_CH1_CYCLE_COUNTS;
            st_q.ch2_cnt  <= lvcd_pkg::RST_CH2_CYCLE_COUNTS;
            // [RL18] first divider active after reset
            st_q.ch1_ctl  <= lvcd_pkg::RST_CH1_START_PHASE;
            st_q.ch1_rt   <= lvcd_pkg::RST_CH1_OUTPUT_ROUTING;
            // [RL5] second divider starts bypassed
            st_q.ch2_ctl  <= lvcd_pkg::RST_CH2_CONTROL;
            st_q.ch2_rt   <= lvcd_pkg::RST_CH2_OUTPUT_ROUTING;
            st_q.src      <= lvcd_pkg::RST_DIST_SOURCE;
        end
        else
        begin
            st_q <= st_d;
        end
    end

endmodule // lvcd_top

//--- verif/lvcd_checker.sv
// port-level assertions for the channel divider block
`timescale 1ns/1ps
module lvcd_checker (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        pair_b_out_p,
    input wire logic        pair_b_out_n,
    input wire logic        pair_c_out_p,
    input wire logic        pair_c_out_n,
    input wire logic [1:0]  duty_correct_on
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_pair_b;
        pair_b_out_n == !pair_b_out_p;
    endproperty
    a_pair_b: assert property (p_pair_b)
        else $error("pair b legs not complementary");
    property p_pair_c;
        pair_c_out_n == !pair_c_out_p;
    endproperty
    a_pair_c: assert property (p_pair_c)
        else $error("pair c legs not complementary");
    property p_duty;
        $rose(arst_n) |-> duty_correct_on == 2'b11;
    endproperty
    a_duty: assert property (p_duty)
        else $error("duty correction off after reset");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold)
        else $error("write response not held");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold)
        else $error("read data not held");
    property p_rans;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0;
    endproperty
    a_rans: assert property (p_rans)
        else $error("read answer late or wide");
    property p_wblock;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_wblock: assert property (p_wblock)
        else $error("write taken while response pending");
    property p_bdone;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
    endproperty
    a_bdone: assert property (p_bdone)
        else $error("write response not retired");
endmodule // lvcd_checker

bind lvcd_top lvcd_checker lvcd_checker_i (
    .clk(clk), .arst_n(arst_n), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .pair_b_out_p(pair_b_out_p), .pair_b_out_n(pair_b_out_n),
    .pair_c_out_p(pair_c_out_p), .pair_c_out_n(pair_c_out_n),
    .duty_correct_on(duty_correct_on)
);

//--- verif/test_lvpecl_channel_divider.sv
// self-checking bench for the channel divider block
`timescale 1ns/1ps
module test_lvpecl_channel_divider;
    logic        clk = 1'b0, arst_n = 1'b0;
    logic [11:0] awa = 12'h0, ara = 12'h0;
    logic [31:0] wd = 32'h0, rdo, rd;
    logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic        dclk = 1'b0, osc = 1'b0, ext = 1'b0, sync = 1'b0;
    logic        awr, wr_rdy, bv, arr, rv, bp, bn, cp, cn;
    logic [1:0]  br, rr, dco, resp;
    logic [1:0]  dcnt = 2'h0;
    logic [31:0] seed = 32'hca6012ee;
    int          fails = 0, check_count = 0;
    logic [9:0]  ridx [7] = '{lvcd_pkg::IDX_CH1_CYCLE_COUNTS, lvcd_pkg::IDX_CH1_START_PHASE,
        lvcd_pkg::IDX_CH1_OUTPUT_ROUTING, lvcd_pkg::IDX_CH2_CYCLE_COUNTS,
        lvcd_pkg::IDX_CH2_CONTROL, lvcd_pkg::IDX_CH2_OUTPUT_ROUTING, lvcd_pkg::IDX_DIST_SOURCE};
    logic [7:0]  rexp [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h01};

    lvcd_top lvcd_top_i (
        .clk(clk), .arst_n(arst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdo),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .dist_clk(dclk),
        .internal_oscillator(osc), .ext_clk(ext), .chip_sync(sync), .pair_b_out_p(bp),
        .pair_b_out_n(bn), .pair_c_out_p(cp), .pair_c_out_n(cn), .duty_correct_on(dco)
    );

    initial
    begin
        forever #5 clk = ~clk;
    end

    // divider input at a quarter of clk, slow enough for the synchroniser
    always @(posedge clk)
    begin
        dcnt <= dcnt + 2'h1;
        dclk <= dcnt[1];
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic int plen(input logic [3:0] n);
        return (n + 1) * 4;
    endfunction

    function automatic logic route_exp(input logic [1:0] src, input logic o);
        return (src == 2'h2) ? o : (src == 2'h0) ? ~o : 1'b1;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic a, w, ra, rw;
        a = 1'b0;
        w = 1'b0;
        @(posedge clk);
        awa <= {idx, 2'b00};
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        // readies are combinational: look mid-cycle, act at the edge
        while (!(a && w))
        begin
            @(negedge clk);
            ra = awr & awv;
            rw = wr_rdy & wv;
            @(posedge clk);
            a = a | ra;
            w = w | rw;
            awv <= !a;
            wv <= !w;
        end
        ra = 1'b0;
        while (ra !== 1'b1)
        begin
            @(negedge clk);
            ra = bv;
            resp = br;
            @(posedge clk);
        end
        bry <= 1'b0;
    endtask

    task automatic rdr(input logic [9:0] idx);
        logic t;
        @(posedge clk);
        ara <= {idx, 2'b00};
        arv <= 1'b1;
        rry <= 1'b1;
        t = 1'b0;
        while (t !== 1'b1)
        begin
            @(negedge clk);
            t = arr;
            @(posedge clk);
        end
        arv <= 1'b0;
        t = 1'b0;
        while (t !== 1'b1)
        begin
            @(negedge clk);
            t = rv;
            rd = rdo;
            resp = rr;
            @(posedge clk);
        end
        rry <= 1'b0;
    endtask

    // one full high phase then one full low phase of pair c, in clk cycles
    task automatic meas(output int hi, output int lo);
        hi = 0;
        lo = 0;
        while (cp !== 1'b0 && hi < 300)
        begin
            @(negedge clk);
            hi++;
        end
        while (cp !== 1'b1 && lo < 300)
        begin
            @(negedge clk);
            lo++;
        end
        hi = 0;
        lo = 0;
        while (cp === 1'b1 && hi < 300)
        begin
            @(negedge clk);
            hi++;
        end
        while (cp === 1'b0 && lo < 300)
        begin
            @(negedge clk);
            lo++;
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge clk);
        fails++;
        conclude();
    end

    initial
    begin
        int hi, lo, t;
        int t0 [2];
        logic [7:0] c;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            rdr(ridx[i]);
            chk(rd, {24'h0, rexp[i]}, "reset value");
        end
        rdr(10'h100);
        chk({30'h0, resp}, {30'h0, lvcd_pkg::RESP_SLVERR}, "unmapped read response");
        chk(rd, 32'h0, "unmapped read data");
        $display("done: registers");
        wr(lvcd_pkg::IDX_CH2_CONTROL, 8'h00);
        // all-zero and all-ones counts are the ratio extremes
        for (int k = 0; k < 6; k++)
        begin
            c = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'(rnd());
            wr(lvcd_pkg::IDX_CH2_CYCLE_COUNTS, c);
            rdr(lvcd_pkg::IDX_CH2_CYCLE_COUNTS);
            chk(rd, {24'h0, c}, "count readback");
            repeat (70) @(posedge clk);
            meas(hi, lo);
            chk(hi, plen(c[3:0]), "high phase");
            chk(lo, plen(c[7:4]), "low phase");
        end
        wr(lvcd_pkg::IDX_CH2_CONTROL, 8'h80);
        meas(hi, lo);
        chk({hi[7:0], lo[7:0]}, 16'h0202, "bypass follows input");
        $display("done: divide ratios");
        wr(lvcd_pkg::IDX_CH2_CYCLE_COUNTS, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            c = {3'h0, k[0], (k < 2) ? 4'h0 : 4'(rnd())};
            wr(lvcd_pkg::IDX_CH2_CONTROL, c);
            sync <= 1'b1;
            repeat (12) @(posedge clk);
            @(negedge clk);
            chk(cp, k[0], "level held in sync");
            // release on a fixed input phase so delays compare exactly
            @(posedge clk);
            while (dcnt != 2'h0) @(posedge clk);
            sync <= 1'b0;
            t = 0;
            while (cp === k[0] && t < 300)
            begin
                @(negedge clk);
                t++;
            end
            if (k < 2)
                t0[k] = t;
            else
                chk(t - t0[k - 2], c[3:0] * 4, "phase delay");
        end
        wr(lvcd_pkg::IDX_CH2_CONTROL, 8'h40);
        sync <= 1'b1;
        meas(hi, lo);
        chk(hi, plen(4'h0), "runs with sync ignored");
        @(posedge clk);
        sync <= 1'b0;
        $display("done: sync");
        for (int k = 0; k < 6; k++)
        begin
            wr(lvcd_pkg::IDX_DIST_SOURCE, 8'(k % 3));
            // force level used only with ignore-sync set
            wr((k < 3) ? lvcd_pkg::IDX_CH1_START_PHASE : lvcd_pkg::IDX_CH2_CONTROL, 8'h60);
            wr((k < 3) ? lvcd_pkg::IDX_CH1_OUTPUT_ROUTING : lvcd_pkg::IDX_CH2_OUTPUT_ROUTING, 8'h02);
            c = 8'(rnd());
            osc <= c[0];
            ext <= ~c[0];
            repeat (6) @(posedge clk);
            @(negedge clk);
            chk((k < 3) ? bp : cp, route_exp(2'(k % 3), c[0]), "route");
        end
        wr(lvcd_pkg::IDX_CH2_OUTPUT_ROUTING, 8'h01);
        @(negedge clk);
        chk(dco, 2'b01, "duty correction flags");
        $display("done: routing");
        conclude();
    end
endmodule // test_lvpecl_channel_divider
